// ==== common/bhfs_defs.svh ====
// Purpose: Offsets, field positions, scan start values and counts of the scheduler
// Assumes: Included by the package and the top module
// Notes:   Definitions only
`ifndef BHFS_DEFS_SVH
`define BHFS_DEFS_SVH

`define BHFS_COLS          132
`define BHFS_BAND_LEN      64
`define BHFS_COL_STEP      8'h09
`define BHFS_BAND_STEP     6'h09
`define BHFS_SA_INIT       4'h0
`define BHFS_SB_INIT       4'h5
`define BHFS_SA_LAST       4'h5
`define BHFS_SUB_FIRST     4'h1
`define BHFS_MASK_INIT     8'h01

`define BHFS_OFF_CTRL      12'h000
`define BHFS_OFF_STATUS    12'h004
`define BHFS_OFF_TOTAL     12'h008
`define BHFS_OFF_PRINTED   12'h00C
`define BHFS_OFF_MATCH     12'h010
`define BHFS_OFF_LINE      12'h200
`define BHFS_OFF_LINE_END  12'h40C
`define BHFS_OFF_BAND      12'h600
`define BHFS_OFF_BAND_END  12'h6FC

`define BHFS_CTRL_START    0
`define BHFS_ST_BUSY       0
`define BHFS_ST_DONE       1
`define BHFS_ST_SA_LSB     4
`define BHFS_ST_SB_LSB     8
`define BHFS_ST_SUB_LSB    12

`endif

// ==== common/bhfs_pkg.sv ====
// Purpose: Types of the band hammer fire scheduler
// Assumes: bhfs_defs.svh gives the sizes
// Notes:   All state of the top module lives in one packed record
`include "bhfs_defs.svh"
`default_nettype none
package bhfs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SUB, ST_CMPA, ST_CMPB, ST_OUT, ST_WAIT, ST_CHECK
  } bhfs_phase_t;

  typedef struct packed {
    bhfs_phase_t                       phase;
    logic [3:0]                        subscan;
    logic [3:0]                        first_set_index;
    logic [3:0]                        second_set_index;
    logic [7:0]                        mask;
    logic [7:0]                        data_a;
    logic [7:0]                        data_b;
    logic [7:0]                        buf_ptr;
    logic [5:0]                        band_ptr;
    logic [7:0]                        total;
    logic [7:0]                        printed_cnt;
    logic                              done;
    logic [`BHFS_COLS-1:0]             printed_map;
    logic [`BHFS_COLS-1:0][7:0]        line;
    logic [`BHFS_BAND_LEN-1:0][7:0]    band;
    logic [7:0]                        odd_data;
    logic [7:0]                        even_data;
    logic [8:0]                        odd_set;
    logic [8:0]                        even_set;
    logic                              fire;
    logic [31:0]                       hrdata;
    logic                              wr_pend;
    logic [11:0]                       wr_addr;
  } bhfs_state_t;
endpackage : bhfs_pkg
`default_nettype wire

// ==== rtl/bhfs_top.sv ====
// Purpose: Band printer hammer fire scheduler with AHB-Lite register access
// Assumes: One clock mclk at 10 MHz, synchronous active-low reset rstn
// Notes:   Line buffer and band image are flip-flops loaded over the bus
// Notes on behaviour
// [R1] Fire only where aligned band character equals the buffered user code.
// [R2] Alignment repeats every ninth column from the sub-scan's first column.
// [R3] Nine sub-scans per scan; sub-scan k starts at column k.
// [R4] Matches set working bits; at sub-scan end they go out and fire.
// [R5] Odd-position and even-position matches kept in two registers.
// [R6] Set pulse lines one to nine fire odd or even hammer by board.
// [R7] Scan starts with first set index 0, second set index 5.
// [R8] Band position counter read before testing columns.
// [R9] One-hot scan mask starts at 00000001, walks eight column groups.
// [R10] Band and buffer codes fetched by two pointers and compared.
// [R11] First column match sets odd-match bit chosen by the mask.
// [R12] Both pointers advance nine columns before the second compare.
// [R13] Second column match sets even-match bit chosen by the mask.
// [R14] Mask shifts left per pair; sub-scan ends when it reaches zero.
// [R15] Odd start: odd-match to odd board, even-match to even board.
// [R16] Even start: the two match registers are swapped before output.
// [R17] Set pulses wait for the hammer alignment strobe.
// [R18] Odd start bumps first set index, even start bumps the second.
// [R19] Odd start: first index picks odd board pulse, second the even.
// [R20] Even start: first index to even board, second to odd board.
// [R21] Count printed characters; stop when all buffered ones are printed.
// [R22] First index of 5 ends a scan; indices restore and scanning repeats.
// [R23] Each sub-scan clears both match registers and reloads the mask.
`include "bhfs_defs.svh"
`default_nettype none
module bhfs_top (
  input  wire logic        mclk,                // System clock
  input  wire logic        rstn,                // Sync reset, active low
  input  wire logic        hsel,                // AHB slave select
  input  wire logic [31:0] haddr,               // AHB address
  input  wire logic [1:0]  htrans,              // AHB transfer type
  input  wire logic        hwrite,              // AHB write
  input  wire logic [2:0]  hsize,               // AHB size, word only
  input  wire logic [31:0] hwdata,              // AHB write data
  input  wire logic        hready,              // AHB ready in
  output logic             hreadyout,           // AHB ready out
  output logic             hresp,               // AHB response
  output logic [31:0]      hrdata,              // AHB read data
  input  wire logic [5:0]  band_pos,            // Band position counter
  input  wire logic        hammer_align_strobe, // Columns aligned now
  output logic [7:0]       odd_data,            // Odd board hammer data
  output logic [7:0]       even_data,           // Even board hammer data
  output logic [8:0]       odd_set_pulse,       // Odd board set lines 1-9
  output logic [8:0]       even_set_pulse,      // Even board set lines 1-9
  output logic             fire                 // Set pulses valid
);
  bhfs_pkg::bhfs_state_t s;
  bhfs_pkg::bhfs_state_t next_s;

  // Region decode, shared by read and write paths
  function automatic logic [1:0] region(input logic [11:0] a);
    if (a >= `BHFS_OFF_LINE && a <= `BHFS_OFF_LINE_END)
      return 2'h1;
    else if (a >= `BHFS_OFF_BAND && a <= `BHFS_OFF_BAND_END)
      return 2'h2;
    else
      return 2'h0;
  endfunction : region

  // Set index 1..9 to one-hot set pulse line
  function automatic logic [8:0] set_line(input logic [3:0] idx);
    return (idx == 4'h0 || idx > 4'h9) ? 9'h000 : 9'(9'h001 << (idx - 4'h1));
  endfunction : set_line

  logic        odd_start;
  logic        ptr_ok;
  logic [7:0]  user_code;
  logic        match;
  logic [11:0] rd_addr;
  logic [7:0]  rd_line_idx;
  logic [5:0]  rd_band_idx;
  logic [7:0]  wr_line_idx;
  logic [5:0]  wr_band_idx;
  logic        busy;
  logic [31:0] rd_val;

  assign odd_start   = s.subscan[0];
  assign busy        = (s.phase != bhfs_pkg::ST_IDLE);
  assign ptr_ok      = (s.buf_ptr < 8'(`BHFS_COLS));
  assign user_code   = ptr_ok ? s.line[s.buf_ptr] : 8'h00;
  // Zero code is blank; a column already struck is never struck again
  assign match       = ptr_ok && (user_code != 8'h00)
                       && !s.printed_map[s.buf_ptr]
                       && (user_code == s.band[s.band_ptr]);   // [R1] [R10]
  assign rd_addr     = haddr[11:0];
  assign rd_line_idx = 8'(rd_addr - `BHFS_OFF_LINE >> 2);
  assign rd_band_idx = 6'(rd_addr - `BHFS_OFF_BAND >> 2);
  assign wr_line_idx = 8'(s.wr_addr - `BHFS_OFF_LINE >> 2);
  assign wr_band_idx = 6'(s.wr_addr - `BHFS_OFF_BAND >> 2);

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (region(rd_addr))
      2'h1: rd_val = {24'h000000, s.line[rd_line_idx]};
      2'h2: rd_val = {24'h000000, s.band[rd_band_idx]};
      default: begin
        if (rd_addr == `BHFS_OFF_STATUS) begin
          rd_val[`BHFS_ST_BUSY] = busy;
          rd_val[`BHFS_ST_DONE] = s.done;
          rd_val[`BHFS_ST_SA_LSB +: 4] = s.first_set_index;
          rd_val[`BHFS_ST_SB_LSB +: 4] = s.second_set_index;
          rd_val[`BHFS_ST_SUB_LSB +: 4] = s.subscan;
        end else if (rd_addr == `BHFS_OFF_TOTAL) begin
          rd_val = {24'h000000, s.total};
        end else if (rd_addr == `BHFS_OFF_PRINTED) begin
          rd_val = {24'h000000, s.printed_cnt};
        end else if (rd_addr == `BHFS_OFF_MATCH) begin
          rd_val = {16'h0000, s.data_b, s.data_a};
        end
      end
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.fire = 1'b0;
    // Bus: read data captured at the address phase, stands in data phase
    if (hsel && htrans[1] && hready) begin
      next_s.wr_pend = hwrite;
      next_s.wr_addr = rd_addr;
      if (!hwrite)
        next_s.hrdata = rd_val;
    end else begin
      next_s.wr_pend = 1'b0;
    end
    if (s.wr_pend) begin
      // Tables locked while printing to keep compares coherent
      if (region(s.wr_addr) == 2'h1 && !busy)
        next_s.line[wr_line_idx] = hwdata[7:0];
      else if (region(s.wr_addr) == 2'h2 && !busy)
        next_s.band[wr_band_idx] = hwdata[7:0];
      else if (s.wr_addr == `BHFS_OFF_TOTAL && !busy)
        next_s.total = hwdata[7:0];
      else if (s.wr_addr == `BHFS_OFF_CTRL && hwdata[`BHFS_CTRL_START]
               && !busy) begin
        next_s.done = (s.total == 8'h00);
        next_s.printed_cnt = 8'h00;
        next_s.printed_map = '0;
        next_s.first_set_index = `BHFS_SA_INIT;                 // [R7]
        next_s.second_set_index = `BHFS_SB_INIT;                // [R7]
        next_s.subscan = `BHFS_SUB_FIRST;                       // [R3]
        next_s.phase = (s.total == 8'h00) ? bhfs_pkg::ST_IDLE
                                          : bhfs_pkg::ST_SUB;
      end
    end
    unique case (s.phase)
      bhfs_pkg::ST_IDLE: begin
      end
      bhfs_pkg::ST_SUB: begin
        next_s.data_a = 8'h00;                                  // [R23]
        next_s.data_b = 8'h00;                                  // [R23]
        next_s.mask = `BHFS_MASK_INIT;                          // [R9] [R23]
        next_s.buf_ptr = 8'(s.subscan - 4'h1);                  // [R2] [R3]
        // Band character facing a column is band_pos plus its offset
        next_s.band_ptr = 6'(band_pos + 6'(s.subscan - 4'h1));  // [R8]
        next_s.phase = bhfs_pkg::ST_CMPA;
      end
      bhfs_pkg::ST_CMPA: begin
        if (match) begin
          next_s.data_a = s.data_a | s.mask;                    // [R4] [R11]
          next_s.printed_map[s.buf_ptr] = 1'b1;
          next_s.printed_cnt = 8'(s.printed_cnt + 8'h01);       // [R21]
        end
        next_s.buf_ptr = 8'(s.buf_ptr + `BHFS_COL_STEP);        // [R12]
        next_s.band_ptr = 6'(s.band_ptr + `BHFS_BAND_STEP);     // [R12]
        next_s.phase = bhfs_pkg::ST_CMPB;
      end
      bhfs_pkg::ST_CMPB: begin
        if (match) begin
          next_s.data_b = s.data_b | s.mask;                    // [R5] [R13]
          next_s.printed_map[s.buf_ptr] = 1'b1;
          next_s.printed_cnt = 8'(s.printed_cnt + 8'h01);       // [R21]
        end
        next_s.buf_ptr = 8'(s.buf_ptr + `BHFS_COL_STEP);        // [R2]
        next_s.band_ptr = 6'(s.band_ptr + `BHFS_BAND_STEP);
        next_s.mask = {s.mask[6:0], 1'b0};                      // [R14]
        next_s.phase = (s.mask[7]) ? bhfs_pkg::ST_OUT
                                   : bhfs_pkg::ST_CMPA;         // [R14]
      end
      bhfs_pkg::ST_OUT: begin
        if (odd_start) begin
          next_s.odd_data = s.data_a;                           // [R15]
          next_s.even_data = s.data_b;                          // [R15]
        end else begin
          next_s.odd_data = s.data_b;                           // [R16]
          next_s.even_data = s.data_a;                          // [R16]
        end
        next_s.phase = bhfs_pkg::ST_WAIT;
      end
      bhfs_pkg::ST_WAIT: begin
        if (hammer_align_strobe) begin                          // [R17]
          if (odd_start) begin
            next_s.first_set_index = 4'(s.first_set_index + 4'h1); // [R18]
            next_s.odd_set = set_line(4'(s.first_set_index + 4'h1)); // [R19]
            next_s.even_set = set_line(s.second_set_index);     // [R19]
          end else begin
            next_s.second_set_index = 4'(s.second_set_index + 4'h1); // [R18]
            next_s.even_set = set_line(s.first_set_index);      // [R20]
            next_s.odd_set = set_line(4'(s.second_set_index + 4'h1)); // [R20]
          end
          next_s.fire = 1'b1;                                   // [R4] [R6]
          next_s.phase = bhfs_pkg::ST_CHECK;
        end
      end
      bhfs_pkg::ST_CHECK: begin
        next_s.odd_set = 9'h000;
        next_s.even_set = 9'h000;
        if (s.printed_cnt >= s.total) begin                     // [R21]
          next_s.done = 1'b1;
          next_s.phase = bhfs_pkg::ST_IDLE;
        end else if (s.first_set_index == `BHFS_SA_LAST) begin  // [R22]
          next_s.first_set_index = `BHFS_SA_INIT;
          next_s.second_set_index = `BHFS_SB_INIT;
          next_s.subscan = `BHFS_SUB_FIRST;
          next_s.phase = bhfs_pkg::ST_SUB;
        end else begin
          next_s.subscan = 4'(s.subscan + 4'h1);                // [R3]
          next_s.phase = bhfs_pkg::ST_SUB;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = s.hrdata;
  assign odd_data       = s.odd_data;
  assign even_data      = s.even_data;
  assign odd_set_pulse  = s.odd_set;
  assign even_set_pulse = s.even_set;
  assign fire           = s.fire;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence pair_step_s;
    s.phase == bhfs_pkg::ST_CMPA ##1 s.phase == bhfs_pkg::ST_CMPB;
  endsequence
  sequence last_pair_s;
    s.phase == bhfs_pkg::ST_CMPB && s.mask == 8'h80;
  endsequence

  mask_onehot_a: assert property ((s.phase == bhfs_pkg::ST_CMPA ||   // [R9]
    s.phase == bhfs_pkg::ST_CMPB) |-> $onehot(s.mask))
    else $error("scan mask not one-hot");
  sub_reload_a: assert property (s.phase == bhfs_pkg::ST_SUB |=>      // [R23]
    s.mask == 8'h01 && s.data_a == 8'h00 && s.data_b == 8'h00)
    else $error("sub-scan did not reload mask and match registers");
  pair_advance_a: assert property (pair_step_s |->                    // [R12]
    s.buf_ptr == 8'($past(s.buf_ptr) + 8'h09))
    else $error("pointer not advanced by nine");
  sub_end_a: assert property (last_pair_s |=>                         // [R14]
    s.phase == bhfs_pkg::ST_OUT ##1 s.phase == bhfs_pkg::ST_WAIT)
    else $error("sub-scan did not end after eighth pair");
  odd_match_a: assert property (s.phase == bhfs_pkg::ST_CMPA && match  // [R11]
    |=> (s.data_a & $past(s.mask)) != 8'h00)
    else $error("odd match bit not set");
  even_swap_a: assert property (s.phase == bhfs_pkg::ST_OUT   // [R16]
    && !odd_start
    |=> s.odd_data == $past(s.data_b) && s.even_data == $past(s.data_a))
    else $error("even start data not swapped");
  odd_route_a: assert property (s.phase == bhfs_pkg::ST_OUT   // [R15]
    && odd_start
    |=> s.odd_data == $past(s.data_a) && s.even_data == $past(s.data_b))
    else $error("odd start data misrouted");
  even_match_a: assert property (s.phase == bhfs_pkg::ST_CMPB   // [R13]
    && match |=> (s.data_b & $past(s.mask)) != 8'h00)
    else $error("even match bit not set");
  band_step_a: assert property (pair_step_s |->                 // [R12]
    s.band_ptr == 6'($past(s.band_ptr) + 6'h09))
    else $error("band pointer not advanced by nine");
  sub_start_a: assert property (s.phase == bhfs_pkg::ST_SUB |=>  // [R8]
    s.buf_ptr == 8'({4'h0, $past(s.subscan)} - 8'h01)
    && s.band_ptr == 6'($past(band_pos) + {2'h0, $past(s.subscan)} - 6'h01))
    else $error("sub-scan pointers not loaded from band position");
  // Set lines must never leak outside the one fire cycle
  set_quiet_a: assert property (!s.fire |->                     // [R6]
    s.odd_set == 9'h000 && s.even_set == 9'h000)
    else $error("set lines active without fire");
  fire_strobe_a: assert property (s.fire |->                          // [R17]
    $past(s.phase) == bhfs_pkg::ST_WAIT && $past(hammer_align_strobe))
    else $error("fired without alignment strobe");
  odd_index_a: assert property (s.fire && odd_start |->               // [R18]
    s.first_set_index == 4'($past(s.first_set_index) + 4'h1)
    && s.odd_set == set_line(s.first_set_index)
    && s.even_set == set_line(s.second_set_index))
    else $error("odd start set index or pulse wrong");
  even_index_a: assert property (s.fire && !odd_start |->             // [R20]
    s.second_set_index == 4'($past(s.second_set_index) + 4'h1)
    && s.even_set == set_line(s.first_set_index)
    && s.odd_set == set_line(s.second_set_index))
    else $error("even start set index or pulse wrong");
  scan_wrap_a: assert property (s.phase == bhfs_pkg::ST_CHECK         // [R22]
    && s.printed_cnt < s.total && s.first_set_index == 4'h5
    |=> s.first_set_index == 4'h0 && s.second_set_index == 4'h5
    && s.subscan == 4'h1)
    else $error("scan did not restart indices");
  print_done_a: assert property (s.phase == bhfs_pkg::ST_CHECK        // [R21]
    && s.printed_cnt >= s.total |=> s.done && !busy)
    else $error("print did not finish");
endmodule : bhfs_top
`default_nettype wire

// ==== bench/bhfs_board_model.sv ====
// Purpose: Odd and even hammer driver boards facing the scheduler
// Assumes: Data and set lines are taken in the cycle that fire is high
// Notes:   Counts pulses and hammers; counts set patterns not one-hot
`default_nettype none
module bhfs_board_model (
  input  wire logic       mclk,      // Clock
  input  wire logic [7:0] odd_data,  // Odd board hammer data
  input  wire logic [7:0] even_data, // Even board hammer data
  input  wire logic [8:0] odd_set,   // Odd board set lines
  input  wire logic [8:0] even_set,  // Even board set lines
  input  wire logic       fire,      // Set pulses valid
  output var  int         fires,     // Set pulses taken
  output var  int         hammers,   // Hammers struck
  output var  int         faults     // Set patterns not one-hot
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fires = 0;
    hammers = 0;
    faults = 0;
  end
  always @(posedge mclk) begin
    if (fire === 1'b1) begin
      fires <= fires + 1;
      // A board decodes exactly one set line per pulse
      if (!$onehot(odd_set) || !$onehot(even_set)) begin
        faults <= faults + 1;
      end
      // Every data bit strikes one hammer of the pulsed set
      hammers <= hammers + $countones(odd_data) + $countones(even_data);
    end
  end
endmodule : bhfs_board_model
`default_nettype wire

// ==== bench/bhfs_bench.sv ====
// Purpose: Self-checking bench of the band hammer fire scheduler
// Assumes: Strobe comes from the bench; 18 cycles from sub-scan to wait
// Notes:   Band image code j is 20h+j, so blank columns never match
`include "bhfs_defs.svh"
`default_nettype none
module bhfs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic          mclk = 1'b0;
  logic          rstn = 1'b0;
  logic          hsel = 1'b0;
  logic [31:0]   haddr = 32'h0;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [2:0]    hsize = 3'h2;
  logic [31:0]   hwdata = 32'h0;
  logic          hready;
  logic          hreadyout;
  logic          hresp;
  logic [31:0]   hrdata;
  logic [5:0]    band_pos = 6'h00;
  logic          hammer_align_strobe = 1'b0;
  logic [7:0]    odd_data;
  logic [7:0]    even_data;
  logic [8:0]    odd_set_pulse;
  logic [8:0]    even_set_pulse;
  logic          fire;
  int            bad_count = 0;
  int            checks = 0;
  int            fires;
  int            hammers;
  int            faults;
  int            h0;
  logic [132:1]  match_col = '0;
  // Per sub-scan: odd board set line, even board set line
  logic [3:0]    rows [1:9][0:1] = '{'{4'h1, 4'h5}, '{4'h6, 4'h1},
    '{4'h2, 4'h6}, '{4'h7, 4'h2}, '{4'h3, 4'h7}, '{4'h8, 4'h3},
    '{4'h4, 4'h8}, '{4'h9, 4'h4}, '{4'h5, 4'h9}};

  always #50 mclk = ~mclk;
  assign hready = hreadyout;

  bhfs_top bhfs_top_inst (.mclk(mclk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .band_pos(band_pos),
    .hammer_align_strobe(hammer_align_strobe), .odd_data(odd_data),
    .even_data(even_data), .odd_set_pulse(odd_set_pulse),
    .even_set_pulse(even_set_pulse), .fire(fire));
  bhfs_board_model bhfs_board_model_inst (.mclk(mclk),
    .odd_data(odd_data), .even_data(even_data), .odd_set(odd_set_pulse),
    .even_set(even_set_pulse), .fire(fire), .fires(fires),
    .hammers(hammers), .faults(faults));

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick

  // Bus waits end only on hready or on the bench bound
  task automatic wait_ready;
    int n;
    n = 0;
    tick;
    while (hreadyout !== 1'b1) begin
      tick;
      n++;
      if (n > 50) begin
        bad_count++;
        final_report;
      end
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic [31:0] mask);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp_val(q & mask, exp);
    cmp_val(hresp, 1'b0); // Always OKAY
  endtask : rd_chk

  task automatic load_band;
    for (int j = 0; j < 64; j++) begin
      wr(`BHFS_OFF_BAND + 12'(4 * j), 32'h20 + 32'(j));
    end
  endtask : load_band

  // Hammers aligned with columns k+18g (data A) and k+18g+9 (data B)
  function automatic logic [7:0] exp_bits(input int k, input int off);
    logic [7:0] v;
    int         c;
    v = 8'h00;
    for (int g = 0; g < 8; g++) begin
      c = k + 18 * g + off;
      if (c <= 132) begin
        v[g] = match_col[c];
      end
    end
    return v;
  endfunction : exp_bits

  task automatic run_sub(input int k, input logic [3:0] oi,
                         input logic [3:0] ei);
    logic [7:0] a;
    logic [7:0] b;
    int         n;
    a = exp_bits(k, 0);
    b = exp_bits(k, 9);
    // Wait long enough that the block is in its strobe wait
    repeat (25) begin
      tick;
      cmp_val(fire, 1'b0);
    end
    cmp_val(odd_data, k[0] ? a : b);
    cmp_val(even_data, k[0] ? b : a);
    hammer_align_strobe <= 1'b1;
    n = 0;
    while (fire !== 1'b1 && n < 10) begin
      tick;
      n++;
    end
    hammer_align_strobe <= 1'b0;
    cmp_val(fire, 1'b1);
    if (fire !== 1'b1) begin
      final_report;
    end
    cmp_val(odd_set_pulse, 9'h001 << (oi - 4'h1));
    cmp_val(even_set_pulse, 9'h001 << (ei - 4'h1));
  endtask : run_sub

  task automatic wait_done;
    logic [31:0] q;
    int          n;
    n = 0;
    q = 32'h0;
    while (q[`BHFS_ST_DONE] !== 1'b1) begin
      bus(1'b0, `BHFS_OFF_STATUS, 32'h0, q);
      n++;
      if (n > 40) begin
        bad_count++;
        final_report;
      end
    end
  endtask : wait_done

  initial begin
    repeat (20) tick;
    rstn <= 1'b1;
    tick;
    cmp_val({odd_data, even_data, fire}, 32'h0); // Quiet after reset
    rd_chk(`BHFS_OFF_STATUS, 32'h0, 32'hFFFF_FFFF); // Idle after reset
    rd_chk(12'h100, 32'h0, 32'hFFFF_FFFF); // Unmapped reads zero
    load_band;
    // Matches span first and last groups and column 132
    foreach (match_col[c]) begin
      if (c inside {1, 9, 10, 30, 128, 131, 132}) begin
        match_col[c] = 1'b1;
        wr(`BHFS_OFF_LINE + 12'(4 * (c - 1)), 32'h20 + 32'((c - 1) % 64));
      end
    end
    wr(`BHFS_OFF_TOTAL, 32'h7);
    wr(`BHFS_OFF_CTRL, 32'h1);
    for (int k = 1; k <= 9; k++) begin
      run_sub(k, rows[k][0], rows[k][1]);
    end
    wait_done;
    rd_chk(`BHFS_OFF_STATUS, 32'h2, 32'h3);
    rd_chk(`BHFS_OFF_PRINTED, 32'h7, 32'hFF);
    cmp_val(hammers, 7);
    cmp_val(faults, 0);
    cmp_val(fires, 9);
    // Second reset mid-life; one column matches only after the band moves
    rstn <= 1'b0;
    repeat (2) tick;
    rstn <= 1'b1;
    tick;
    cmp_val({odd_data, even_data, fire}, 32'h0); // Cleared by reset
    rd_chk(`BHFS_OFF_LINE, 32'h0, 32'hFFFF_FFFF); // Tables cleared
    match_col = '0;
    h0 = hammers;
    load_band;
    wr(`BHFS_OFF_LINE + 12'h010, 32'h2C);
    wr(`BHFS_OFF_TOTAL, 32'h1);
    wr(`BHFS_OFF_CTRL, 32'h1);
    wr(`BHFS_OFF_TOTAL, 32'h9);
    for (int k = 1; k <= 9; k++) begin
      run_sub(k, rows[k][0], rows[k][1]);
    end
    band_pos <= 6'h08;
    match_col[5] = 1'b1;
    for (int k = 1; k <= 5; k++) begin
      run_sub(k, rows[k][0], rows[k][1]);
    end
    wait_done;
    rd_chk(`BHFS_OFF_TOTAL, 32'h1, 32'hFF);
    rd_chk(`BHFS_OFF_PRINTED, 32'h1, 32'hFF);
    cmp_val(hammers - h0, 1);
    cmp_val(fires, 23);
    final_report;
  end
endmodule : bhfs_bench
`default_nettype wire
